// *** logic/ccg_pkg.sv ***
package ccg_pkg;
    localparam int unsigned SLOW_CLOCK_HZ = 32768;
    localparam int unsigned ADDR_W = 8;
    localparam logic [7:0] OFF_OSC_CTRL = 8'h00;
    localparam logic [7:0] OFF_FREQ = 8'h04;
    localparam logic [7:0] OFF_PLL_A = 8'h08;
    localparam logic [7:0] OFF_PLL_B = 8'h0c;
    localparam logic [7:0] OFF_STATUS = 8'h10;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h14;
    localparam logic [7:0] OFF_IRQ_CLEAR = 8'h18;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h1c;
    localparam int OSC_EN_BIT = 0;
    localparam int BYPASS_BIT = 1;
    localparam int OSC_CNT_LSB = 8;
    localparam int OSC_CNT_W = 8;
    localparam int PRESCALE_W = 3;
    localparam int FREQ_CNT_W = 16;
    localparam int FREQ_DONE_BIT = 16;
    localparam logic [4:0] MEASURE_FALLS = 5'h10;
    localparam int DIV_LSB = 0;
    localparam int DIV_W = 8;
    localparam int SETTLE_LSB = 8;
    localparam int SETTLE_W = 6;
    localparam int FACTOR_LSB = 16;
    localparam int FACTOR_W = 11;
    localparam int EV_OSC_STABLE = 0;
    localparam int EV_PLL_A = 1;
    localparam int EV_PLL_B = 2;
    localparam int EV_FREQ_DONE = 3;
    localparam int EV_W = 4;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** logic/ccg_pll_lock.sv ***
`timescale 1ns/1ps
`default_nettype none
module ccg_pll_lock (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic cfg_write,
    input wire logic [31:0] cfg_wdata,
    input wire logic slow_tick,
    output logic [31:0] cfg_word,
    output logic [7:0] ratio,
    output logic [10:0] factor,
    output logic running,
    output logic settled
);
    logic [7:0] ratio_reg;
    logic [10:0] factor_reg;
    logic [5:0] settle_reg;
    logic [5:0] count_reg;
    logic settled_reg;
    logic [7:0] ratio_next;
    logic [10:0] factor_next;
    logic [5:0] settle_next;
    logic changed;

    assign ratio_next = cfg_wdata[ccg_pkg::DIV_LSB +: ccg_pkg::DIV_W];
    assign factor_next = cfg_wdata[ccg_pkg::FACTOR_LSB +: ccg_pkg::FACTOR_W];
    assign settle_next = cfg_wdata[ccg_pkg::SETTLE_LSB +: ccg_pkg::SETTLE_W];
    // a rewrite of identical values leaves a settled pll alone
    assign changed = cfg_write && ({ratio_next, factor_next, settle_next} != {ratio_reg, factor_reg, settle_reg});
    // ratio 0 or factor 0 keeps the analog cell stopped and its output low
    assign running = (ratio_reg != 8'h00) && (factor_reg != 11'h000);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ratio_reg <= 8'h00;
            factor_reg <= 11'h000;
            settle_reg <= 6'h00;
            count_reg <= 6'h00;
            settled_reg <= 1'b0;
        end else if (changed) begin
            ratio_reg <= ratio_next;
            factor_reg <= factor_next;
            settle_reg <= settle_next;
            count_reg <= settle_next;
            settled_reg <= 1'b0;
        end else if (!running) begin
            settled_reg <= 1'b0;
        end else if (slow_tick && !settled_reg) begin
            if (count_reg == 6'h00) begin
                settled_reg <= 1'b1;
            end else begin
                count_reg <= count_reg - 6'h01;
            end
        end
    end

    assign cfg_word = {5'h00, factor_reg, 2'h0, settle_reg, ratio_reg};
    assign ratio = ratio_reg;
    assign factor = factor_reg;
    assign settled = settled_reg;
endmodule
`default_nettype wire

// *** logic/ccg_clock_ctrl.sv ***
// The AXI4-Lite interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module ccg_clock_ctrl (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic slow_clock,
    input wire logic main_osc_clock,
    output logic osc_enable,
    output logic external_clock_select,
    output logic osc_stable,
    output logic slow_clock_selected,
    output logic [7:0] pll_a_ratio,
    output logic [10:0] pll_a_factor,
    output logic pll_a_run,
    output logic [7:0] pll_b_ratio,
    output logic [10:0] pll_b_factor,
    output logic pll_b_run,
    output logic irq
);
    typedef enum logic [3:0] {
        MEAS_IDLE = 4'h1,
        MEAS_WAIT_RISE = 4'h2,
        MEAS_COUNT = 4'h4,
        MEAS_DONE = 4'h8
    } ccg_meas_t;

    function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // input synchronisers and edge detection

    logic slow_s1_reg, slow_s2_reg, slow_s3_reg;
    logic main_s1_reg, main_s2_reg, main_s3_reg;
    logic slow_rise, slow_fall, main_rise;

    // both clocks are slower than aclk; first stage feeds only the second
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            slow_s1_reg <= 1'b0;
            slow_s2_reg <= 1'b0;
            slow_s3_reg <= 1'b0;
            main_s1_reg <= 1'b0;
            main_s2_reg <= 1'b0;
            main_s3_reg <= 1'b0;
        end else begin
            slow_s1_reg <= slow_clock;
            slow_s2_reg <= slow_s1_reg;
            slow_s3_reg <= slow_s2_reg;
            main_s1_reg <= main_osc_clock;
            main_s2_reg <= main_s1_reg;
            main_s3_reg <= main_s2_reg;
        end
    end

    // every slow clock derived counter steps on these edges
    assign slow_rise = slow_s2_reg && !slow_s3_reg;
    assign slow_fall = !slow_s2_reg && slow_s3_reg;
    // limitation: main clock is only counted exactly below aclk / 2
    assign main_rise = main_s2_reg && !main_s3_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // axi4-lite write path

    logic aw_held_reg, w_held_reg, bvalid_reg;
    logic [7:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic [1:0] bresp_reg;
    logic wr_fire;
    logic wr_osc, wr_pll_a, wr_pll_b, wr_clear, wr_mask, wr_hit;

    assign s_axi_awready = !aw_held_reg && !bvalid_reg;
    assign s_axi_wready = !w_held_reg && !bvalid_reg;
    assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
    assign wr_osc = wr_fire && (aw_addr_reg == ccg_pkg::OFF_OSC_CTRL);
    assign wr_pll_a = wr_fire && (aw_addr_reg == ccg_pkg::OFF_PLL_A);
    assign wr_pll_b = wr_fire && (aw_addr_reg == ccg_pkg::OFF_PLL_B);
    assign wr_clear = wr_fire && (aw_addr_reg == ccg_pkg::OFF_IRQ_CLEAR);
    assign wr_mask = wr_fire && (aw_addr_reg == ccg_pkg::OFF_IRQ_MASK);
    assign wr_hit = wr_osc || wr_pll_a || wr_pll_b || wr_clear || wr_mask;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg <= ccg_pkg::RESET_WORD;
            w_strb_reg <= 4'h0;
            bresp_reg <= ccg_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= {s_axi_awaddr[7:2], 2'h0};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                bvalid_reg <= 1'b1;
                // read-only and unmapped words answer with slverr and change nothing
                bresp_reg <= wr_hit ? ccg_pkg::RESP_OKAY : ccg_pkg::RESP_SLVERR;
            end else if (bvalid_reg && s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // main oscillator control and startup counter

    logic [31:0] osc_word, osc_new;
    logic osc_en_reg, bypass_reg, stable_reg, osc_run_reg;
    logic [7:0] osc_count_reg, osc_cnt_reg;
    logic [2:0] prescale_reg;
    logic osc_tick;

    assign osc_word = {16'h0000, osc_count_reg, 6'h00, bypass_reg, osc_en_reg};
    assign osc_new = merge(osc_word, w_data_reg, w_strb_reg);
    // one tick every eighth slow clock period
    assign osc_tick = slow_rise && (prescale_reg == 3'h7);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            osc_en_reg <= 1'b0;
            bypass_reg <= 1'b0;
            osc_count_reg <= 8'h00;
            osc_cnt_reg <= 8'h00;
            osc_run_reg <= 1'b0;
            stable_reg <= 1'b0;
            prescale_reg <= 3'h0;
        end else begin
            if (slow_rise) begin
                prescale_reg <= prescale_reg + 3'h1;
            end
            if (wr_osc) begin
                osc_en_reg <= osc_new[ccg_pkg::OSC_EN_BIT];
                bypass_reg <= osc_new[ccg_pkg::BYPASS_BIT];
                osc_count_reg <= osc_new[ccg_pkg::OSC_CNT_LSB +: ccg_pkg::OSC_CNT_W];
            end
            if (wr_osc && !osc_new[ccg_pkg::OSC_EN_BIT]) begin
                stable_reg <= 1'b0;
                osc_run_reg <= 1'b0;
            end else if (wr_osc) begin
                stable_reg <= 1'b0;
                osc_run_reg <= 1'b1;
                osc_cnt_reg <= osc_new[ccg_pkg::OSC_CNT_LSB +: ccg_pkg::OSC_CNT_W];
                prescale_reg <= 3'h0;
            end else if (osc_run_reg && osc_tick) begin
                if (osc_cnt_reg == 8'h00) begin
                    stable_reg <= 1'b1;
                    osc_run_reg <= 1'b0;
                end else begin
                    osc_cnt_reg <= osc_cnt_reg - 8'h01;
                end
            end
        end
    end

    assign osc_enable = osc_en_reg;
    assign external_clock_select = bypass_reg;
    assign osc_stable = stable_reg;
    // the slow clock stays the source until the oscillator is proven stable
    assign slow_clock_selected = !stable_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // main clock frequency measurement

    ccg_meas_t meas_reg, meas_next;
    logic [15:0] freq_cnt_reg;
    logic [4:0] falls_reg;
    logic meas_done;

    always_comb begin
        meas_next = meas_reg;
        case (meas_reg)
            MEAS_IDLE: begin
                if (stable_reg) begin
                    meas_next = MEAS_WAIT_RISE;
                end
            end
            MEAS_WAIT_RISE: begin
                if (slow_rise) begin
                    meas_next = MEAS_COUNT;
                end
            end
            MEAS_COUNT: begin
                if (slow_fall && (falls_reg == ccg_pkg::MEASURE_FALLS - 5'h01)) begin
                    meas_next = MEAS_DONE;
                end
            end
            MEAS_DONE: begin
                meas_next = MEAS_DONE;
            end
            default: begin
                meas_next = MEAS_IDLE;
            end
        endcase
        // losing the oscillator voids any measurement in progress
        if (!stable_reg) begin
            meas_next = MEAS_IDLE;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meas_reg <= MEAS_IDLE;
            freq_cnt_reg <= 16'h0000;
            falls_reg <= 5'h00;
        end else begin
            meas_reg <= meas_next;
            if (meas_reg == MEAS_WAIT_RISE) begin
                freq_cnt_reg <= 16'h0000;
                falls_reg <= 5'h00;
            end else if (meas_reg == MEAS_COUNT) begin
                if (main_rise) begin
                    freq_cnt_reg <= freq_cnt_reg + 16'h0001;
                end
                if (slow_fall) begin
                    falls_reg <= falls_reg + 5'h01;
                end
            end
        end
    end

    assign meas_done = (meas_reg == MEAS_DONE);

    ////////////////////////////////////////////////////////////////////////////////
    // pll a and pll b with their lock counters

    logic [31:0] pll_a_word, pll_b_word;
    logic pll_a_settled, pll_b_settled;

    ccg_pll_lock u_pll_a (
        .aclk(aclk),
        .aresetn(aresetn),
        .cfg_write(wr_pll_a),
        .cfg_wdata(merge(pll_a_word, w_data_reg, w_strb_reg)),
        .slow_tick(slow_rise),
        .cfg_word(pll_a_word),
        .ratio(pll_a_ratio),
        .factor(pll_a_factor),
        .running(pll_a_run),
        .settled(pll_a_settled)
    );

    ccg_pll_lock u_pll_b (
        .aclk(aclk),
        .aresetn(aresetn),
        .cfg_write(wr_pll_b),
        .cfg_wdata(merge(pll_b_word, w_data_reg, w_strb_reg)),
        .slow_tick(slow_rise),
        .cfg_word(pll_b_word),
        .ratio(pll_b_ratio),
        .factor(pll_b_factor),
        .running(pll_b_run),
        .settled(pll_b_settled)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // interrupt status, clear and mask

    logic [3:0] flags, flags_d_reg, ev_status_reg, ev_mask_reg, ev_rise;
    logic [31:0] mask_new;

    // only the low four bits of the merged word are kept
    assign mask_new = merge({28'h0000000, ev_mask_reg}, w_data_reg, w_strb_reg);

    assign flags = {meas_done, pll_b_settled, pll_a_settled, stable_reg};
    assign ev_rise = flags & ~flags_d_reg;

    // a new event in the clearing cycle wins over the clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flags_d_reg <= 4'h0;
            ev_status_reg <= 4'h0;
            ev_mask_reg <= 4'h0;
        end else begin
            flags_d_reg <= flags;
            ev_status_reg <= (ev_status_reg & ~(wr_clear ? w_data_reg[3:0] : 4'h0)) | ev_rise;
            if (wr_mask) begin
                ev_mask_reg <= mask_new[3:0];
            end
        end
    end

    assign irq = |(ev_status_reg & ev_mask_reg);

    ////////////////////////////////////////////////////////////////////////////////
    // axi4-lite read path

    logic rvalid_reg;
    logic [31:0] rdata_reg, rd_word;
    logic [1:0] rresp_reg;
    logic rd_hit;

    assign s_axi_arready = !rvalid_reg;
    assign rd_hit = (s_axi_araddr[7:2] <= ccg_pkg::OFF_IRQ_MASK[7:2]) && (s_axi_araddr[7:2] != ccg_pkg::OFF_IRQ_CLEAR[7:2]);

    always_comb begin
        case ({s_axi_araddr[7:2], 2'h0})
            ccg_pkg::OFF_OSC_CTRL: rd_word = osc_word;
            ccg_pkg::OFF_FREQ: rd_word = {15'h0000, meas_done, freq_cnt_reg};
            ccg_pkg::OFF_PLL_A: rd_word = pll_a_word;
            ccg_pkg::OFF_PLL_B: rd_word = pll_b_word;
            ccg_pkg::OFF_STATUS: rd_word = {28'h0000000, flags};
            ccg_pkg::OFF_IRQ_STATUS: rd_word = {28'h0000000, ev_status_reg};
            ccg_pkg::OFF_IRQ_MASK: rd_word = {28'h0000000, ev_mask_reg};
            default: rd_word = ccg_pkg::RESET_WORD;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= ccg_pkg::RESET_WORD;
            rresp_reg <= ccg_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_hit ? rd_word : ccg_pkg::RESET_WORD;
            rresp_reg <= rd_hit ? ccg_pkg::RESP_OKAY : ccg_pkg::RESP_SLVERR;
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
endmodule
`default_nettype wire

// *** sim/ccg_osc_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module ccg_osc_model #(
    parameter int SLOW_HALF_NS = 15259,
    parameter int MAIN_HALF_NS = 150
) (
    input wire logic osc_enable,
    input wire logic external_clock_select,
    output logic slow_clock,
    output logic main_osc_clock
);
    initial begin
        slow_clock = 1'b0;
        forever #(SLOW_HALF_NS) slow_clock = ~slow_clock;
    end
    // an unpowered crystal gives no edges, so unless bypass is selected the line rests low
    initial begin
        main_osc_clock = 1'b0;
        forever begin
            #(MAIN_HALF_NS);
            main_osc_clock = (osc_enable || external_clock_select) ? ~main_osc_clock : 1'b0;
        end
    end
endmodule
`default_nettype wire

// *** sim/ccg_clock_ctrl_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module ccg_clock_ctrl_chk (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic osc_enable,
    input wire logic osc_stable,
    input wire logic slow_clock_selected,
    input wire logic [7:0] pll_a_ratio,
    input wire logic [10:0] pll_a_factor,
    input wire logic pll_a_run,
    input wire logic [7:0] pll_b_ratio,
    input wire logic [10:0] pll_b_factor,
    input wire logic pll_b_run
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    slow_select_a: assert property (slow_clock_selected == !osc_stable)
        else $error("source select wrong");
    stable_needs_en_a: assert property (osc_stable |-> osc_enable)
        else $error("stable while disabled");
    disable_clears_a: assert property ($fell(osc_enable) |-> !osc_stable)
        else $error("stable kept after disable");
    enable_clears_a: assert property ($rose(osc_enable) |-> !osc_stable [*8])
        else $error("stable too early");
    pll_a_run_a: assert property (pll_a_run == (pll_a_ratio != 8'h00 && pll_a_factor != 11'h000))
        else $error("pll a run wrong");
    pll_b_run_a: assert property (pll_b_run == (pll_b_ratio != 8'h00 && pll_b_factor != 11'h000))
        else $error("pll b run wrong");
    ratio_reset_a: assert property ($rose(aresetn) |-> pll_a_ratio == 8'h00 && pll_b_ratio == 8'h00)
        else $error("ratio not zero after reset");
    write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer late");
    one_bresp_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("extra write answer");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer late");
    stable_cov: cover property ($rose(osc_stable));
    pll_cov: cover property ($rose(pll_a_run));
    off_cov: cover property ($fell(osc_stable));
endmodule
bind ccg_clock_ctrl ccg_clock_ctrl_chk i_chk (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .osc_enable(osc_enable), .osc_stable(osc_stable),
    .slow_clock_selected(slow_clock_selected), .pll_a_ratio(pll_a_ratio), .pll_a_factor(pll_a_factor),
    .pll_a_run(pll_a_run), .pll_b_ratio(pll_b_ratio), .pll_b_factor(pll_b_factor), .pll_b_run(pll_b_run)
);
`default_nettype wire

// *** sim/ccg_clock_ctrl_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module ccg_clock_ctrl_tb_top;
    localparam int SLOW_CYC = 48;
    localparam logic [1:0] OK = ccg_pkg::RESP_OKAY;
    localparam logic [1:0] ERR = ccg_pkg::RESP_SLVERR;
    typedef struct {logic rd; logic [31:0] d; logic [31:0] m; logic [1:0] r;} ccg_exp_t;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
    logic rvalid, rready, slow_clock, main_osc_clock, osc_enable, external_clock_select;
    logic osc_stable, slow_clock_selected, pll_a_run, pll_b_run, irq;
    logic [7:0] awaddr, araddr, pll_a_ratio, pll_b_ratio, a, ratio;
    logic [10:0] pll_a_factor, pll_b_factor, fac;
    logic [31:0] wdata, rdata, q, w;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    ccg_exp_t exp_q[$];
    ccg_exp_t e;
    int err_count, check_count, cycles, n, k;
    ////////////////////////////////////////
    ccg_clock_ctrl i_dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .slow_clock(slow_clock), .main_osc_clock(main_osc_clock),
        .osc_enable(osc_enable), .external_clock_select(external_clock_select), .osc_stable(osc_stable),
        .slow_clock_selected(slow_clock_selected), .pll_a_ratio(pll_a_ratio), .pll_a_factor(pll_a_factor),
        .pll_a_run(pll_a_run), .pll_b_ratio(pll_b_ratio), .pll_b_factor(pll_b_factor), .pll_b_run(pll_b_run),
        .irq(irq)
    );
    // slow clock sped up to 48 aclk periods, else one startup alone costs tens of thousands of cycles
    ccg_osc_model #(.SLOW_HALF_NS(SLOW_CYC * 25), .MAIN_HALF_NS(150)) i_osc (.osc_enable(osc_enable),
        .external_clock_select(external_clock_select), .slow_clock(slow_clock), .main_osc_clock(main_osc_clock));
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end
    ////////////////////////////////////////
    task automatic fail(input string s);
        err_count++;
        $display("MISMATCH %0t %s", $time, s);
    endtask
    task automatic cmp(input logic [31:0] g, input logic [31:0] x, input string s);
        check_count++;
        if (g !== x) fail(s);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic wr(input logic [7:0] ad, input logic [31:0] d, input logic [3:0] s, input logic [1:0] r);
        int t;
        bit done;
        @(posedge aclk);
        exp_q.push_back('{1'b0, 32'h0, 32'h0, r});
        awaddr <= ad;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        t = 0;
        done = 0;
        while (!done && t < 100) begin
            @(posedge aclk);
            t++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                bready <= 1'b0;
                done = 1;
            end
        end
        if (!done) fail("write hang");
    endtask
    task automatic rd(input logic [7:0] ad, input logic [31:0] d, m, input logic [1:0] r, output logic [31:0] v);
        int t;
        bit done;
        @(posedge aclk);
        exp_q.push_back('{1'b1, d, m, r});
        araddr <= ad;
        arvalid <= 1'b1;
        rready <= 1'b1;
        t = 0;
        done = 0;
        v = 32'h0;
        while (!done && t < 100) begin
            @(posedge aclk);
            t++;
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                v = rdata;
                rready <= 1'b0;
                done = 1;
            end
        end
        if (!done) fail("read hang");
    endtask
    task automatic poll(input logic [7:0] ad, input int b);
        int i;
        q = 32'h0;
        for (i = 0; i < 400 && q[b] !== 1'b1; i++) rd(ad, 32'h0, 32'h0, OK, q);
        cmp(q[b], 1, "flag never set");
    endtask
    ////////////////////////////////////////
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles > 40000) begin
            fail("timeout");
            end_of_test();
        end
        if (aresetn && ((bvalid && bready) || (rvalid && rready))) begin
            e = exp_q.pop_front();
            cmp({30'h0, rvalid ? rresp : bresp}, {30'h0, e.r}, "response code");
            if (e.rd) cmp(rdata & e.m, e.d & e.m, "read data");
        end
    end
    initial begin
        void'($urandom(32'h73ad9fb0));
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
        {awaddr, araddr, wdata, wstrb} = 52'h0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        for (k = 0; k < 9; k++) rd(8'(k * 4), 32'h0, 32'hffffffff, (k == 6 || k == 8) ? ERR : OK, q);
        cmp({slow_clock_selected, osc_enable}, 2'h2, "reset source");
        wr(ccg_pkg::OFF_FREQ, 32'hffffffff, 4'hf, ERR);
        wr(ccg_pkg::OFF_IRQ_MASK, 32'hf, 4'h0, OK);
        rd(ccg_pkg::OFF_IRQ_MASK, 32'h0, 32'hffffffff, OK, q);
        $display("test register map done");
        k = $urandom_range(3, 1);
        wr(ccg_pkg::OFF_IRQ_MASK, 32'h1, 4'hf, OK);
        wr(ccg_pkg::OFF_OSC_CTRL, 32'(k << 8) | 32'h1, 4'hf, OK);
        cmp(osc_stable, 0, "stable after enable");
        for (n = 0; n < 5000 && osc_stable !== 1'b1; n++) @(posedge aclk);
        check_count++;
        if (n < (8 * (k + 1) - 1) * SLOW_CYC || n > 8 * (k + 1) * SLOW_CYC + 8) fail("startup time");
        // status bit is registered one edge after the flag rises
        repeat (2) @(posedge aclk);
        cmp(irq, 1, "stable interrupt");
        rd(ccg_pkg::OFF_STATUS, 32'h1, 32'h1, OK, q);
        wr(ccg_pkg::OFF_IRQ_CLEAR, 32'h1, 4'hf, OK);
        cmp(irq, 0, "interrupt clear");
        poll(ccg_pkg::OFF_FREQ, ccg_pkg::FREQ_DONE_BIT);
        check_count++;
        if ((q[15:0] >= 16'd120 && q[15:0] <= 16'd130) !== 1'b1) fail("main cycle count");
        wr(ccg_pkg::OFF_OSC_CTRL, 32'h0, 4'hf, OK);
        cmp(osc_stable, 0, "stable after disable");
        rd(ccg_pkg::OFF_FREQ, 32'h0, 32'h10000, OK, q);
        wr(ccg_pkg::OFF_OSC_CTRL, 32'h2, 4'hf, OK);
        cmp({external_clock_select, osc_enable}, 2'h2, "bypass");
        $display("test oscillator done");
        for (k = 0; k < 2; k++) begin
            a = k ? ccg_pkg::OFF_PLL_B : ccg_pkg::OFF_PLL_A;
            ratio = k ? 8'hff : 8'($urandom_range(254, 1));
            fac = 11'($urandom_range(2047, 1));
            w = {5'h0, fac, 2'h0, 6'h03, ratio};
            wr(ccg_pkg::OFF_IRQ_MASK, 32'h2 << k, 4'hf, OK);
            // charge pump is outside this block and taken as already set up
            wr(a, w, 4'hf, OK);
            rd(a, w, 32'h07ff3fff, OK, q);
            cmp(k ? {pll_b_run, pll_b_factor, pll_b_ratio} : {pll_a_run, pll_a_factor, pll_a_ratio},
                {1'b1, fac, ratio}, "pll outputs");
            poll(ccg_pkg::OFF_STATUS, 1 + k);
            cmp(irq, 1, "lock interrupt");
            wr(ccg_pkg::OFF_IRQ_CLEAR, 32'h2 << k, 4'hf, OK);
            wr(a, w & 32'hf800ffff, 4'hf, OK);
            rd(ccg_pkg::OFF_STATUS, 32'h0, 32'h2 << k, OK, q);
            wr(a, w & 32'hffffff00, 4'hf, OK);
            cmp(k ? pll_b_run : pll_a_run, 0, "pll held off");
            $display("test pll %0d done", k);
        end
        end_of_test();
    end
endmodule
`default_nettype wire
